// ===== rtl/control_mode_strap_select.sv
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module control_mode_strap_select
  import strap_mode_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [1:0] RANGE_MODE_STRAP,
  input wire logic [1:0] OUTPUT_EDGE_SELECT,
  input wire logic [1:0] CALIBRATION_DELAY_SELECT,
  input wire logic SERIAL_CLOCK,
  output logic EXTENDED_MODE,
  output logic RANGE_810_MV,
  output logic DATA_EDGE_POSITIVE,
  output logic DATA_READY_CLOCK_DDR,
  output logic CAL_DELAY_LONG,
  output logic SERIAL_ENABLE,
  output logic ALL_CONFIG_WRITTEN
);

  // Comparator pair to three levels
  function automatic tri_lvl_t resolve(input logic [1:0] c);
    unique case (c)
      2'b00: resolve = LVL_LOW;
      2'b11: resolve = LVL_HIGH;
      default: resolve = LVL_FLOAT;
    endcase
  endfunction

  logic [5:0] strap_s1_q, strap_s2_q, strap_s3_q, strap_q;
  tri_lvl_t range_lvl, edge_lvl, cal_lvl;
  mode_sel_t mode_d, mode_q;
  logic serial_en_q;

  // Three-stage strap sync, bit taken once stages two and three agree
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_s1_q <= STRAP_RST;
      strap_s2_q <= STRAP_RST;
      strap_s3_q <= STRAP_RST;
      strap_q <= STRAP_RST;
    end else begin
      strap_s1_q <= {CALIBRATION_DELAY_SELECT, OUTPUT_EDGE_SELECT,
                     RANGE_MODE_STRAP};
      strap_s2_q <= strap_s1_q;
      strap_s3_q <= strap_s2_q;
      strap_q <= (strap_s3_q & ~(strap_s2_q ^ strap_s3_q)) |
                 (strap_q & (strap_s2_q ^ strap_s3_q));
    end
  end

  // Level resolution of each strap
  assign range_lvl = resolve(strap_q[1:0]);
  assign edge_lvl = resolve(strap_q[3:2]);
  assign cal_lvl = resolve(strap_q[5:4]);

  // Mode and function decode
  always_comb begin
    mode_d.ext = (range_lvl == LVL_FLOAT);
    mode_d.range_hi = !mode_d.ext && (range_lvl == LVL_HIGH);
    mode_d.ddr = !mode_d.ext && (edge_lvl == LVL_FLOAT);
    mode_d.edge_pos = !mode_d.ext && (edge_lvl == LVL_HIGH);
    mode_d.cal_long = !mode_d.ext &&
                      (cal_lvl == LVL_HIGH);
  end

  // Registered selections
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_q <= '0;
      serial_en_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      serial_en_q <= mode_d.ext;
    end
  end

  // Serial link, runs on the serial clock only while selected
  logic serial_data_pin, scs_idle, link_rst_n;
  logic [FRAME_BITS-1:0] shift_q;
  logic [4:0] bitcnt_q;
  frame_t word_q;
  logic tog_q;

  assign serial_data_pin = OUTPUT_EDGE_SELECT[1];
  assign scs_idle = CALIBRATION_DELAY_SELECT[1];
  assign link_rst_n = RESET_N & ~scs_idle;

  // Frame shifter, cleared whenever select goes high
  always_ff @(posedge SERIAL_CLOCK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      shift_q <= '0;
      bitcnt_q <= 5'h00;
    end else if (bitcnt_q < 5'(FRAME_BITS)) begin
      shift_q <= {shift_q[FRAME_BITS-2:0], serial_data_pin};
      bitcnt_q <= bitcnt_q + 5'h01;
    end
  end

  // Completed frame held, toggle announces it
  always_ff @(posedge SERIAL_CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      word_q <= '0;
      tog_q <= 1'b0;
    end else if (!scs_idle && bitcnt_q == 5'(FRAME_BITS - 1)) begin
      word_q <= {shift_q[FRAME_BITS-2:0], serial_data_pin};
      tog_q <= ~tog_q;
    end
  end

  // Toggle crossing into the system clock
  logic tog_s1_q, tog_s2_q, tog_s3_q, tog_st_q;
  logic word_evt;
  assign word_evt = (tog_s2_q == tog_s3_q) && (tog_s3_q != tog_st_q);

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
      tog_st_q <= 1'b0;
    end else begin
      tog_s1_q <= tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
      if (tog_s2_q == tog_s3_q) begin
        tog_st_q <= tog_s3_q;
      end
    end
  end

  // Configuration store, loaded from frames in extended mode only
  logic [FR_DATA_W-1:0] cfg_mem [CFG_COUNT];
  logic [5:0] written_q;
  logic lock_q, clr_written, cfg_load;
  assign cfg_load = word_evt && mode_q.ext && !lock_q &&
                    (word_q.addr < 4'(CFG_COUNT));

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < CFG_COUNT; i++) begin
        cfg_mem[i] <= CFG_RST;
      end
    end else if (cfg_load) begin
      cfg_mem[word_q.addr[2:0]] <= word_q.data;
    end
  end

  // Written mask, a new write beats a clear
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      written_q <= WRITTEN_RST;
    end else begin
      written_q <= (clr_written ? WRITTEN_RST : written_q) |
                   (cfg_load ? 6'(6'h01 << word_q.addr[2:0]) : 6'h00);
    end
  end

  // Bus slave, zero wait states
  logic wr_pend_q;
  logic [7:0] waddr_q;
  logic [31:0] rdata_d, rdata_q;
  logic acc;
  assign acc = HSEL && HTRANS[1] && HREADY;
  assign clr_written = wr_pend_q && waddr_q == CTRL_OFS &&
                       HWDATA[CTRL_CLR_BIT];

  // Read mux on the address phase
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (HADDR[7:0] == CTRL_OFS) begin
      rdata_d[CTRL_LOCK_BIT] = lock_q;
    end else if (HADDR[7:0] == STATUS_OFS) begin
      rdata_d[ST_MODE_LSB +: 5] = mode_q;
      rdata_d[ST_ALL_BIT] = &written_q;
      rdata_d[ST_LOCK_BIT] = lock_q;
      rdata_d[ST_WR_LSB +: 6] = written_q;
    end else begin
      for (int i = 0; i < CFG_COUNT; i++) begin
        if (HADDR[7:0] == CFG_BASE_OFS + 8'(4 * i)) begin
          rdata_d[FR_DATA_W-1:0] = cfg_mem[i];
        end
      end
    end
  end

  // Address phase capture
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_pend_q <= 1'b0;
      waddr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= acc && HWRITE;
      waddr_q <= HADDR[7:0];
      if (acc && !HWRITE) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // Control register write in the data phase
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lock_q <= 1'b0;
    end else if (wr_pend_q && waddr_q == CTRL_OFS) begin
      lock_q <= HWDATA[CTRL_LOCK_BIT];
    end
  end

  // Registered outputs
  logic all_q;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      all_q <= 1'b0;
    end else begin
      all_q <= &written_q;
    end
  end

  // Bus answer flags, zero wait states and always OKAY
  logic hready_q, hresp_q;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  assign EXTENDED_MODE = mode_q.ext;
  assign RANGE_810_MV = mode_q.range_hi;
  assign DATA_EDGE_POSITIVE = mode_q.edge_pos;
  assign DATA_READY_CLOCK_DDR = mode_q.ddr;
  assign CAL_DELAY_LONG = mode_q.cal_long;
  assign SERIAL_ENABLE = serial_en_q;
  assign ALL_CONFIG_WRITTEN = all_q;
  assign HRDATA = rdata_q;
  assign HREADYOUT = hready_q;
  assign HRESP = hresp_q;

  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  sequence s_range_float;
    strap_q[1:0] == 2'b01 || strap_q[1:0] == 2'b10;
  endsequence
  sequence s_range_driven;
    strap_q[1:0] == 2'b00 || strap_q[1:0] == 2'b11;
  endsequence
  sequence s_edge_float;
    strap_q[3:2] == 2'b01 || strap_q[3:2] == 2'b10;
  endsequence

  // Mode entry from the range strap
  a_ext_mode_entry: assert property (
    s_range_float |=> EXTENDED_MODE && SERIAL_ENABLE)
    else $error("floating range strap did not enter extended mode");
  a_pin_mode_entry: assert property (
    s_range_driven |=> !EXTENDED_MODE && !SERIAL_ENABLE)
    else $error("driven range strap did not give pin mode");
  a_ext_clears: assert property (
    s_range_float |=>
      !RANGE_810_MV && !DATA_EDGE_POSITIVE && !DATA_READY_CLOCK_DDR)
    else $error("pin mode selection active in extended mode");

  // Pin mode selections
  a_range_pick: assert property (
    s_range_driven |=> RANGE_810_MV == $past(strap_q[1]))
    else $error("full-scale range does not follow range strap");
  a_edge_pick: assert property (
    s_range_driven ##0 strap_q[3:2] == 2'b11 |=>
      DATA_EDGE_POSITIVE && !DATA_READY_CLOCK_DDR)
    else $error("high edge strap did not select rising edge");
  a_edge_neg: assert property (
    s_range_driven ##0 strap_q[3:2] == 2'b00 |=>
      !DATA_EDGE_POSITIVE && !DATA_READY_CLOCK_DDR)
    else $error("low edge strap did not select falling edge");
  a_ddr_pick: assert property (
    s_range_driven ##0 strap_q[3:2] == 2'b01 |=>
      DATA_READY_CLOCK_DDR && !DATA_EDGE_POSITIVE)
    else $error("floating edge strap did not select double rate");
  a_ddr_both: assert property (
    s_range_driven ##0 s_edge_float |=> DATA_READY_CLOCK_DDR)
    else $error("either floating edge code must select double rate");
  a_cal_pick: assert property (
    s_range_driven ##0 strap_q[5:4] == 2'b11 |=> CAL_DELAY_LONG)
    else $error("high delay strap did not select long delay");
  a_cal_short_pin: assert property (
    s_range_driven ##0 strap_q[5:4] != 2'b11 |=> !CAL_DELAY_LONG)
    else $error("low or floating delay strap gave long delay");
  a_cal_short_ext: assert property (
    EXTENDED_MODE |-> !CAL_DELAY_LONG)
    else $error("long delay while in extended mode");

  // Frame acceptance and strap sync
  a_frame_gate: assert property (
    word_evt && !mode_q.ext |=> $stable(written_q) || $past(clr_written))
    else $error("serial frame accepted outside extended mode");
  a_frame_load: assert property (
    cfg_load |=> written_q[$past(word_q.addr[2:0])])
    else $error("accepted frame did not mark its location");
  a_strap_agree: assert property (
    ((strap_q ^ $past(strap_q)) &
     ($past(strap_s2_q) ^ $past(strap_s3_q))) == 6'h00)
    else $error("strap bit changed before its sync stages agreed");
  a_frame_len: assert property (
    @(posedge SERIAL_CLOCK) disable iff (!link_rst_n)
    bitcnt_q <= 5'(FRAME_BITS))
    else $error("serial bit counter overran frame");

endmodule

// ===== rtl/strap_mode_pkg.sv
// How it works
// - Range strap driven high or low: pin mode, serial frames ignored.
// - Range strap floating: extended mode, settings from serial port.
// - Pin mode: range strap low gives 600 mV, high gives 810 mV.
// - Pin mode: edge strap low launches on falling, high on rising.
// - Pin mode: edge strap floating gives double data rate clock.
// - Pin mode: delay strap low picks short, high picks long delay.
// - Extended mode: short delay always, delay pin is serial enable.
// - Extended mode: serial clock, data on edge pin, select on delay pin.
package strap_mode_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] CFG_BASE_OFS = 8'h08;
  localparam int CFG_COUNT = 6;

  // Control register fields
  localparam int CTRL_LOCK_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;

  // Status register fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_ALL_BIT = 5;
  localparam int ST_LOCK_BIT = 6;
  localparam int ST_WR_LSB = 8;

  // Serial frame layout: address on top, data below
  localparam int FRAME_BITS = 16;
  localparam int FR_ADDR_LSB = 12;
  localparam int FR_DATA_W = 12;

  // Reset values
  localparam logic [5:0] STRAP_RST = 6'h00;
  localparam logic [5:0] WRITTEN_RST = 6'h00;
  localparam logic [FR_DATA_W-1:0] CFG_RST = 12'h000;

  // Resolved strap level
  typedef enum logic [2:0] {
    LVL_LOW = 3'b001,
    LVL_HIGH = 3'b010,
    LVL_FLOAT = 3'b100
  } tri_lvl_t;

  // Decoded operating selections
  typedef struct packed {
    logic cal_long;
    logic ddr;
    logic edge_pos;
    logic range_hi;
    logic ext;
  } mode_sel_t;

  // One serial frame
  typedef struct packed {
    logic [3:0] addr;
    logic [FR_DATA_W-1:0] data;
  } frame_t;

endpackage

// ===== test/strap_host_model.sv
`timescale 1ns/1ps
module strap_host_model (
  input wire logic mclk,
  output logic [1:0] range_code,
  output logic [1:0] edge_code,
  output logic [1:0] delay_code,
  output logic sclk
);
  // Straps start driven low, serial clock parked low
  initial begin
    range_code = 2'b00;
    edge_code = 2'b00;
    delay_code = 2'b00;
    sclk = 1'b0;
  end

  // Strap levels change just after a system clock edge
  task automatic set_straps(input logic [1:0] r, e, d);
    @(posedge mclk);
    range_code <= r;
    edge_code <= e;
    delay_code <= d;
  endtask

  // One frame, address then data, MSB first, clock only inside frame
  task automatic send_frame(input logic [3:0] a, input logic [11:0] v);
    logic [15:0] f;
    #1; // Off the system clock edge, phase unrelated
    f = {a, v};
    delay_code = 2'b00; // Select low
    for (int i = 15; i >= 0; i--) begin
      edge_code = {2{f[i]}}; // Data on edge pin
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    #80 delay_code = 2'b11; // Select released
    edge_code = ~edge_code; // Released data loses its last level
    #200;
  endtask
endmodule

// ===== test/control_mode_strap_select_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module control_mode_strap_select_tb;
  import strap_mode_pkg::*;
  logic mclk, reset_n, hsel, hwrite, hready, hresp, sclk, all_wr;
  logic [1:0] htrans, rng, edg, dly;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [5:0] mode, expm;
  logic [1:0] ecode [4] = '{2'b00, 2'b11, 2'b01, 2'b10};
  int n_errors = 0;
  int n_checks = 0;

  strap_host_model strap_host_model_inst (.mclk(mclk), .range_code(rng),
    .edge_code(edg), .delay_code(dly), .sclk(sclk));

  control_mode_strap_select control_mode_strap_select_inst (.MCLK(mclk),
    .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .RANGE_MODE_STRAP(rng), .OUTPUT_EDGE_SELECT(edg),
    .CALIBRATION_DELAY_SELECT(dly), .SERIAL_CLOCK(sclk),
    .EXTENDED_MODE(mode[0]), .RANGE_810_MV(mode[1]),
    .DATA_EDGE_POSITIVE(mode[2]), .DATA_READY_CLOCK_DDR(mode[3]),
    .CAL_DELAY_LONG(mode[4]), .SERIAL_ENABLE(mode[5]),
    .ALL_CONFIG_WRITTEN(all_wr));

  // System clock, 4 ns period
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  // One single-word transfer; read data taken at the data phase edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask

  // Verdict and end of run
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    #200000;
    n_errors++;
    results;
  end

  // Main sequence
  initial begin
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    reset_n = 1'b0;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    // Pin mode: range and delay low and high, all edge levels, both floating codes
    for (int i = 0; i < 16; i++) begin
      expm = {1'b0, i[0], ^ecode[i[2:1]], ecode[i[2:1]] == 2'b11, i[3], 1'b0};
      strap_host_model_inst.set_straps({2{i[3]}}, ecode[i[2:1]], {2{i[0]}});
      repeat (10) @(posedge mclk);
      `CHK(mode, expm)
      bus(1'b0, STATUS_OFS, 32'h0);
      `CHK(rdv, {27'h0, expm[4:0]})
    end
    // A frame in pin mode is ignored; released pins set 810 mV, long delay
    strap_host_model_inst.send_frame(4'h0, 12'h777);
    bus(1'b0, STATUS_OFS, 32'h0);
    `CHK(rdv, 32'h0000_0012)
    // Floating range strap, both codes: extended mode, short delay
    strap_host_model_inst.set_straps(2'b01, 2'b00, 2'b11);
    repeat (10) @(posedge mclk);
    `CHK(mode, 6'h21)
    strap_host_model_inst.set_straps(2'b10, 2'b00, 2'b11);
    repeat (10) @(posedge mclk);
    `CHK(mode, 6'h21)
    // Host writes all six locations before calibrating
    for (int i = 0; i < 6; i++) begin
      `CHK(all_wr, 1'b0)
      strap_host_model_inst.send_frame(i[3:0], 12'ha50 + 12'(i));
    end
    `CHK(all_wr, 1'b1)
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, CFG_BASE_OFS + 8'(4 * i), 32'h0);
      `CHK(rdv, {20'h0, 12'ha50 + 12'(i)})
    end
    // Lock during calibration: a stray frame must not land
    bus(1'b1, CTRL_OFS, 32'h1);
    strap_host_model_inst.send_frame(4'h0, 12'h123);
    bus(1'b0, STATUS_OFS, 32'h0);
    `CHK(rdv, 32'h3f61)
    bus(1'b0, CFG_BASE_OFS, 32'h0);
    `CHK(rdv, 32'ha50)
    // Clear written mask, then an unmapped read
    bus(1'b1, CTRL_OFS, 32'h2);
    repeat (4) @(posedge mclk);
    `CHK(all_wr, 1'b0)
    bus(1'b0, 8'h40, 32'h0);
    `CHK(rdv, 32'h0)
    `CHK(hresp, 1'b0)
    `CHK(hready, 1'b1)
    results;
  end
endmodule
